/* File: shared/led_ctrl_pkg.sv */
/*
 * constants for the led enable and pwm brightness decoder.
 * assumes a 125 mhz system clock; enable pins arrive asynchronously.
 */
package led_ctrl_pkg;
  localparam int unsigned CLK_MHZ          = 125;        // clock rate in mhz
  localparam int unsigned HOLDOFF_US       = 200;        // shutdown hold-off in us
  localparam int unsigned HOLDOFF_CYC      = HOLDOFF_US * CLK_MHZ; // whole cycles
  localparam int unsigned LOW_BANK_N       = 5;          // low bank outputs
  localparam int unsigned HIGH_BANK_N      = 2;          // high bank outputs
  localparam int unsigned OUT_N            = LOW_BANK_N + HIGH_BANK_N;
  localparam int unsigned CNT_W            = 16;         // period counter width
  localparam int unsigned BIN_N            = 8;          // brightness bins
  localparam logic [7:0]  STEP_RESET       = 8'h00;      // zero current after reset
  localparam logic [3:0]  SOFTSTART_CYC    = 4'hf;       // soft-start settle count
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;   // counter reset value
endpackage

/* File: design/led_enable_decoder.sv */
/*
 * led bank enable / shutdown control and pwm duty decoder.
 * assumes enable pins from the host are asynchronous; led detect, forward
 * voltage compare and fault flags come from same-clock analog front logic.
 */
`timescale 1ns/1ps
// Functional notes
// RULE1: run if either enable high
// RULE2: low-bank rising edge wakes immediately
// RULE3: hold 200us after falling edge before shutdown
// RULE4: host pwm 10 to 50 khz
// RULE5: eight equal bins, exponential current steps
// RULE6: duty is high-time fraction of period
// RULE7: decoding only low bank; high bank on/off
// RULE8: detect unused outputs at startup, disable
// RULE9: select largest forward voltage output for feedback
// RULE10: soft-start rearmed by shutdown, uvlo, overtemp
// RULE11: count cycles, update step once per period
module led_enable_decoder #(
  parameter int unsigned HOLDOFF = led_ctrl_pkg::HOLDOFF_CYC // hold-off cycles
) (
  input  wire logic       clk_i,            // 125 mhz clock
  input  wire logic       reset_n_i,        // sync reset, active low
  input  wire logic       en_low_i,         // low bank enable / pwm pin
  input  wire logic       en_high_i,        // high bank enable pin
  input  wire logic [6:0] led_present_i,    // led seen by detect current
  input  wire logic [6:0] vf_high_i,        // one-hot-or-more: needs most headroom
  input  wire logic       uvlo_i,           // undervoltage event
  input  wire logic       overtemp_i,       // overtemperature event
  output logic            run_o,            // device running
  output logic [7:0]      low_bank_full_current_o, // low bank step, 128 = full
  output logic            high_bank_full_current_o,// high bank on at full
  output logic [6:0]      source_en_o,      // current source enables
  output logic [2:0]      fb_sel_o,         // controlling output index
  output logic            soft_start_o      // soft-start in progress
);
  // refuse hold-off lengths that the counter or the checks below cannot serve;
  // the hold-off check expects at least eight cycles of running after a fall
  if (HOLDOFF < 16 || HOLDOFF > 32'h00ffffff) begin : g_bad_holdoff
    $error("bad HOLDOFF");
  end

  // whole state of the block
  typedef struct packed {
    logic [1:0]  low_sync;   // low pin synchroniser
    logic [1:0]  high_sync;  // high pin synchroniser
    logic        low_prev;   // last synced low level
    logic        run;        // running
    logic [23:0] hold;       // hold-off countdown
    logic [15:0] hi_cnt;     // high cycles this period
    logic [15:0] per_cnt;    // total cycles this period
    logic [7:0]  step;       // low bank current step
    logic        detected;   // led detect done
    logic [6:0]  used;       // outputs with led attached
    logic [3:0]  ss_cnt;     // soft-start counter
    logic        ss_done;    // soft-start complete
    logic [2:0]  fb;         // feedback output
  } state_t;

  state_t q, d;

  // map a bin index to an exponential step
  function automatic logic [7:0] step_of(input logic [2:0] bin);
    step_of = 8'(8'h01 << bin);
  endfunction

  logic low_s, high_s, rise, fall;
  logic [18:0] scaled; // hi_cnt * 8
  logic [2:0]  bin;

  // next-state logic
  // the enable pins pass two synchroniser stages before anything reads them.
  // run rises as soon as either synced enable is high; leaving run needs both
  // low and the hold-off countdown run out, so pwm dimming on the low pin
  // never drops the device into shutdown between pulses.
  // duty is measured from one synced rising edge of the low pin to the next:
  // high cycles against all cycles, scaled by eight and compared with each
  // bin boundary; an exact boundary lands in the lower bin.
  // a saturated period counter means the pin has stopped toggling: a pin
  // stuck high gives full current, a pin stuck low gives none.
  always_comb begin
    d      = q;
    low_s  = q.low_sync[1];
    high_s = q.high_sync[1];
    rise   = low_s & ~q.low_prev;
    fall   = ~low_s & q.low_prev;
    scaled = {q.hi_cnt, 3'h0};
    bin    = 3'h0;
    d.low_sync  = {q.low_sync[0], en_low_i};
    d.high_sync = {q.high_sync[0], en_high_i};
    d.low_prev  = low_s;
    // run / shutdown decision
    if (high_s || low_s) begin
      d.run  = 1'b1;                                   // see RULE1 see RULE2
      d.hold = 24'(HOLDOFF);
    end else if (q.run) begin
      if (fall) d.hold = 24'(HOLDOFF);                 // see RULE3
      else if (q.hold != 24'h0) d.hold = q.hold - 24'h1;
      if (q.hold == 24'h1) d.run = 1'b0;               // see RULE3
    end
    // duty measurement over each period, rising edge to rising edge
    if (rise) begin
      if (q.per_cnt != 16'h0) begin
        for (int i = 1; i < 8; i++) begin
          if (scaled > 19'(q.per_cnt) * 19'(i)) bin = 3'(i); // see RULE5
        end
        d.step = step_of(bin);                         // see RULE11
      end
      d.hi_cnt  = 16'h1;
      d.per_cnt = 16'h1;
    end else begin
      if (low_s && q.hi_cnt != 16'hffff) d.hi_cnt = q.hi_cnt + 16'h1; // see RULE6
      if (q.per_cnt != 16'hffff) d.per_cnt = q.per_cnt + 16'h1;
    end
    // constant high: full current; long idle low: zero
    if (q.per_cnt == 16'hffff) d.step = low_s ? 8'h80 : 8'h00;      // see RULE5
    if (!q.run) d.step = led_ctrl_pkg::STEP_RESET;
    // led detect once per startup; the detect result stays until shutdown,
    // so an led switched in later is only seen after the next wake
    if (q.run && !q.detected) begin
      d.used     = led_present_i;                      // see RULE8
      d.detected = 1'b1;
    end
    // soft-start: counts up once after wake, then stays done until shutdown
    // or a supply or temperature fault re-arms it
    if (!q.run || uvlo_i || overtemp_i) begin
      d.ss_cnt   = 4'h0;                               // see RULE10
      d.ss_done  = 1'b0;
      d.detected = q.run ? q.detected : 1'b0;
    end else if (!q.ss_done) begin
      d.ss_cnt = q.ss_cnt + 4'h1;
      if (q.ss_cnt == led_ctrl_pkg::SOFTSTART_CYC) d.ss_done = 1'b1;
    end
    // controlling output: lowest index among used needing most headroom
    d.fb = q.fb;
    for (int k = 6; k >= 0; k--) begin
      if (vf_high_i[k] && q.used[k]) d.fb = 3'(k);    // see RULE9
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs
  // all outputs come straight from the state register or from a gate of
  // registered terms, so none of them follows a pin without synchronising
  assign run_o                    = q.run;
  assign low_bank_full_current_o  = q.step;                     // see RULE7
  assign high_bank_full_current_o = q.run & q.high_sync[1];     // see RULE7
  assign source_en_o              = q.detected ? q.used : 7'h00; // see RULE8
  assign fb_sel_o                 = q.fb;
  assign soft_start_o             = q.run & ~q.ss_done;

  // assertions
  run_on_enable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE1
    (q.low_sync[1] || q.high_sync[1]) |=> q.run) else $error("not running while enabled");
  wake_fast_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE2
    $rose(q.low_sync[1]) |=> q.run) else $error("slow wake");
  hold_run_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE3
    ($fell(q.low_sync[1]) && !q.high_sync[1] && q.run) |=> q.run [*8])
    else $error("dropped during hold-off");
  step_onehot_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE5
    $onehot0(q.step)) else $error("step not exponential");
  zero_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE5
    !q.run |=> q.step == 8'h00) else $error("current while shut down");
  step_per_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE11
    $changed(q.step) |-> ($past(rise) || !$past(q.run) || $past(q.per_cnt) == 16'hffff))
    else $error("step changed mid period");
  unused_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE8
    (source_en_o & ~q.used) == 7'h00) else $error("unused source on");
  fb_used_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE9
    $changed(q.fb) |-> q.used[q.fb]) else $error("feedback on unused output");
  ss_rearm_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE10
    (q.ss_done && q.run && !uvlo_i && !overtemp_i) |=> q.ss_done)
    else $error("soft-start rearmed");
  shut_both_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE1
    $fell(q.run) |-> (!$past(q.low_sync[1]) && !$past(q.high_sync[1])))
    else $error("shut down while enabled");
  hold_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE3
    (q.run && !q.low_sync[1] && !q.high_sync[1] && q.hold > 24'h1) |=> q.run)
    else $error("hold-off cut short");
  detect_once_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE8
    $changed(q.used) |-> !$past(q.detected))
    else $error("led detect repeated while running");

  // cover the main scenarios: wake, shutdown, full step, mid step, re-arm
  wake_c: cover property (@(posedge clk_i) !q.run ##1 q.run);
  mid_c: cover property (@(posedge clk_i) q.step == 8'h08);
  rearm_c: cover property (@(posedge clk_i) (q.run && q.ss_done) ##1 !q.ss_done);
  shut_c: cover property (@(posedge clk_i) q.run ##1 !q.run);
  full_c: cover property (@(posedge clk_i) q.step == 8'h80);
endmodule

/* File: bench/host_pwm_model.sv */
/* host driving the low bank enable pin: pwm or a static level.
   assumes the testbench sets period and high time in clock cycles. */
`timescale 1ns/1ps
module host_pwm_model (
  input  wire logic        clk_i,    // system clock
  input  wire logic        pwm_on_i, // run pwm when high
  input  wire logic        level_i,  // static pin level when pwm off
  input  wire logic [15:0] hi_i,     // high cycles per period
  input  wire logic [15:0] per_i,    // period in cycles
  output logic             en_o      // enable pin to the device
);
  logic [15:0] cnt_q; // position in the current period
  // period counter and pin, changed just after each edge
  always @(posedge clk_i) begin
    cnt_q <= (!pwm_on_i || cnt_q >= per_i - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    en_o  <= #1 pwm_on_i ? (cnt_q < hi_i) : level_i;
  end
endmodule

/* File: bench/led_enable_decoder_tb.sv */
/* self-checking bench for the enable and brightness decoder.
   assumes a shortened hold-off, longer than the pwm low time. */
`timescale 1ns/1ps
module led_enable_decoder_tb;
  localparam int unsigned HOLD = 3000; // sim hold-off in cycles
  logic clk_i = 1'b0, reset_n_i = 1'b0, en_high_i = 1'b0, uvlo_i = 1'b0;
  logic overtemp_i = 1'b0, pwm_on = 1'b0, lvl = 1'b0;
  logic [6:0]  led_present_i = 7'h5b; // outputs 0,1,3,4,6 used
  logic [6:0]  vf_high_i = 7'h48;     // lowest used needing headroom is 3
  logic [15:0] hi = 16'h0000, per = 16'h09c4; // 2500 cycle period
  logic en_low_i, run_o, high_o, soft_o;
  logic [7:0] step_o;
  logic [6:0] src_o;
  logic [2:0] fb_o;
  int fail_count = 0, compares = 0;
  always #4 clk_i = ~clk_i; // 125 mhz
  host_pwm_model u_host_pwm_model (.clk_i(clk_i), .pwm_on_i(pwm_on), .level_i(lvl),
    .hi_i(hi), .per_i(per), .en_o(en_low_i));
  led_enable_decoder #(.HOLDOFF(HOLD)) u_led_enable_decoder (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .en_low_i(en_low_i), .en_high_i(en_high_i),
    .led_present_i(led_present_i), .vf_high_i(vf_high_i), .uvlo_i(uvlo_i),
    .overtemp_i(overtemp_i), .run_o(run_o), .low_bank_full_current_o(step_o),
    .high_bank_full_current_o(high_o), .source_en_o(src_o), .fb_sel_o(fb_o),
    .soft_start_o(soft_o));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for a run level; running out ends the run
  task automatic wait_run(input logic v, input int n);
    int i;
    i = 0;
    while (run_o !== v && i < n) begin
      tick(1);
      i++;
    end
    chk("run_o", {7'h00, v}, {7'h00, run_o});
    if (run_o !== v) final_report();
  endtask
  task automatic t_wake();
    lvl = 1'b1;
    wait_run(1'b1, 5);
    chk("soft_start", 8'h01, {7'h00, soft_o});
    tick(30);
    chk("source_en", 8'h5b, {1'b0, src_o});
    chk("fb_sel", 8'h03, {5'h00, fb_o});
  endtask
  // mid-bin duty for every bin, three periods each
  task automatic t_bins();
    pwm_on = 1'b1;
    for (int k = 0; k < 8; k++) begin
      hi = 16'(156 + 312 * k);
      tick(7500);
      chk("step", 8'h01 << k, step_o);
      chk("run_pwm", 8'h01, {7'h00, run_o});
      chk("high_off", 8'h00, {7'h00, high_o});
    end
  endtask
  task automatic t_high();
    en_high_i = 1'b1;
    tick(5);
    chk("high_on", 8'h01, {7'h00, high_o});
    chk("step_hi", 8'h80, step_o);
    en_high_i = 1'b0;
  endtask
  task automatic t_hold();
    pwm_on = 1'b0;
    lvl = 1'b0;
    tick(HOLD - 100);
    lvl = 1'b1;
    tick(3);
    lvl = 1'b0;
    tick(HOLD - 10);
    chk("run_held", 8'h01, {7'h00, run_o});
    wait_run(1'b0, 20);
    tick(1);
    chk("step_off", 8'h00, step_o);
  endtask
  task automatic t_uvlo();
    t_wake();
    chk("soft_done", 8'h00, {7'h00, soft_o});
    uvlo_i = 1'b1;
    tick(1);
    uvlo_i = 1'b0;
    tick(3);
    chk("soft_rearm", 8'h01, {7'h00, soft_o});
    tick(20);
    chk("soft_done2", 8'h00, {7'h00, soft_o});
    overtemp_i = 1'b1;
    tick(1);
    overtemp_i = 1'b0;
    tick(3);
    chk("soft_ot", 8'h01, {7'h00, soft_o});
  endtask
  initial begin
    tick(12);
    reset_n_i = 1'b1;
    tick(1);
    chk("run_rst", 8'h00, {7'h00, run_o});
    t_wake();
    t_bins();
    t_high();
    t_hold();
    t_uvlo();
    final_report();
  end
endmodule
